// file: testbench/oodg_divider_model.sv
// offset pin dividers seen through the shared converter
`timescale 1ns/1ns
`default_nettype none
module oodg_divider_model (
  // clock
  input wire logic clk,
  // converter handshake
  input wire logic start,
  input wire logic sel_nb,
  output logic done,
  output logic [5:0] ratio,
  // pin levels in 1/64 of supply
  input wire logic [5:0] core_lvl,
  input wire logic [5:0] nb_lvl,
  input wire logic slow
);
  logic sel_q;
  int cnt;
  initial
  begin
    done = 1'b0;
    ratio = 6'h00;
    sel_q = 1'b0;
    cnt = -1;
  end
  // result is invalid until done: keep it toggling
  always @(posedge clk)
    if (start)
    begin
      done <= 1'b0;
      ratio <= ~ratio;
      sel_q <= sel_nb;
      cnt <= slow ? 6 : 1;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      ratio <= ~ratio;
    end
    else if (cnt == 0)
    begin
      done <= 1'b1;
      ratio <= sel_q ? nb_lvl : core_lvl;
      cnt <= -1;
    end
endmodule : oodg_divider_model
`default_nettype wire

// file: testbench/oodg_properties.sv
// port checker for the offset decode and gating block
`timescale 1ns/1ns
`default_nettype none
module oodg_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched ports
  input wire logic adc_start_q,
  input wire logic adc_sel_nb_q,
  input wire logic serial_vid_mode,
  input wire logic fixed_voltage_test_mode,
  input wire logic soft_start_active,
  input wire logic power_good_input,
  input wire logic [oodg_pkg::OFS_W-1:0] core_offset_q,
  input wire logic [oodg_pkg::OFS_W-1:0] northbridge_offset_pin_q,
  input wire logic core_offset_on_q,
  input wire logic northbridge_offset_pin_on_q,
  input wire logic normal_q
);
  logic last_q, last_d, seen_q, seen_d;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_comb
  begin
    last_d = adc_start_q ? adc_sel_nb_q : last_q;
    seen_d = seen_q | adc_start_q;
  end
  always_ff @(posedge clk)
  begin
    last_q <= sys_rst ? 1'b0 : last_d;
    seen_q <= sys_rst ? 1'b0 : seen_d;
  end
  AST_START_ONE: assert property (adc_start_q |=> !adc_start_q)
    else $error("start pulse longer than one cycle");
  AST_ALTERNATE: assert property (adc_start_q && seen_q |->
    adc_sel_nb_q != last_q) else $error("pin select did not alternate");
  AST_RANGE: assert property (core_offset_q <= 6'h20 &&
    northbridge_offset_pin_q <= 6'h20) else $error("offset above 800 mV");
  AST_NO_775: assert property (core_offset_q != 6'h1f &&
    northbridge_offset_pin_q != 6'h1f) else $error("775 mV offset produced");
  AST_SOFT: assert property (soft_start_active [*6] |->
    !core_offset_on_q && !northbridge_offset_pin_on_q) else $error("offset in soft-start");
  AST_FIXED: assert property (fixed_voltage_test_mode [*6] |->
    !core_offset_on_q && !northbridge_offset_pin_on_q) else $error("offset in fixed mode");
  AST_PARALLEL: assert property (!serial_vid_mode [*6] |->
    !northbridge_offset_pin_on_q) else $error("northbridge_offset_pin in parallel mode");
  AST_ON_NORMAL: assert property (core_offset_on_q || northbridge_offset_pin_on_q |->
    normal_q) else $error("offset applied outside normal");
  AST_PG_LOSS: assert property (!power_good_input [*6] |-> !normal_q)
    else $error("normal without power good");
  cover property (core_offset_on_q && northbridge_offset_pin_on_q);
  cover property (core_offset_on_q && !northbridge_offset_pin_on_q);
  cover property ($fell(normal_q));
endmodule : oodg_properties
bind oodg_top oodg_properties u_props (.clk(clk), .sys_rst(sys_rst),
  .adc_start_q(adc_start_q), .adc_sel_nb_q(adc_sel_nb_q),
  .serial_vid_mode(serial_vid_mode),
  .fixed_voltage_test_mode(fixed_voltage_test_mode),
  .soft_start_active(soft_start_active),
  .power_good_input(power_good_input), .core_offset_q(core_offset_q),
  .northbridge_offset_pin_q(northbridge_offset_pin_q), .core_offset_on_q(core_offset_on_q),
  .northbridge_offset_pin_on_q(northbridge_offset_pin_on_q), .normal_q(normal_q));
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for offset decode and gating
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, sys_rst = 1, serial = 0, fixed = 0, pg = 0, ss = 0, vid = 0;
  logic start, sel, done, slow = 0, c_on, n_on, norm;
  logic [5:0] ratio, c_lvl = 0, n_lvl = 0, c_ofs, n_ofs;
  logic [11:0] ref_c = 12'h0320, ref_n = 12'h0258, c_tgt, n_tgt;
  int miscompares = 0, num_checks = 0;
  initial forever #10 clk = ~clk;
  oodg_top u_dut (.clk(clk), .sys_rst(sys_rst), .adc_sel_nb_q(sel),
    .adc_start_q(start), .adc_done(done), .adc_ratio(ratio),
    .serial_vid_mode(serial), .fixed_voltage_test_mode(fixed),
    .power_good_input(pg), .soft_start_active(ss), .vid_code_valid(vid),
    .reference_dac_value(ref_c), .nb_reference_dac_value(ref_n),
    .core_target_q(c_tgt), .nb_target_q(n_tgt), .core_offset_q(c_ofs),
    .northbridge_offset_pin_q(n_ofs), .core_offset_on_q(c_on), .northbridge_offset_pin_on_q(n_on),
    .normal_q(norm));
  oodg_divider_model u_pins (.clk(clk), .start(start), .sel_nb(sel),
    .done(done), .ratio(ratio), .core_lvl(c_lvl), .nb_lvl(n_lvl),
    .slow(slow));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(string what, logic [11:0] got, logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [5:0] exp_ofs(logic [5:0] r);
    if (r < 6'h03)
      return 6'h00;
    if (r == 6'h3f)
      return 6'h20;
    return ((r - 6'h03) >> 1) + 6'h01;
  endfunction : exp_ofs
  // wait until both pins have been converted afresh
  task automatic gate(string what, logic ce, logic ne);
    int k;
    logic [5:0] ec, en;
    k = 0;
    for (int i = 0; i < 400 && k < 3; i++)
    begin
      @(posedge clk);
      if (start === 1'b1)
        k++;
    end
    if (k < 3)
    begin
      miscompares++;
      complete_run();
    end
    else
    begin
      repeat (3) @(posedge clk);
      // look between edges, where the registered outputs have settled
      @(negedge clk);
      ec = ce ? exp_ofs(c_lvl) : 6'h00;
      en = ne ? exp_ofs(n_lvl) : 6'h00;
      chk({what, " on"}, {9'h0, norm, c_on, n_on}, {9'h0, ce, ce, ne});
      chk({what, " core ofs"}, {6'h00, c_ofs}, {6'h00, ec});
      chk({what, " nb ofs"}, {6'h00, n_ofs}, {6'h00, en});
      chk({what, " core tgt"}, c_tgt, ref_c + 12'(ec) * 12'h019);
      chk({what, " nb tgt"}, n_tgt, ref_n + 12'(en) * 12'h019);
      $display("done %s", what);
      @(posedge clk);
    end
  endtask : gate
  task automatic rst_seq(logic s);
    sys_rst <= 1'b1;
    serial <= s;
    fixed <= 1'b0;
    pg <= 1'b0;
    vid <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    ss <= 1'b1;
  endtask : rst_seq
  task automatic sweep;
    logic [5:0] r[8] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h3d, 6'h3e,
      6'h3f};
    foreach (r[i])
    begin
      c_lvl <= r[i];
      n_lvl <= ~r[i];
      gate("sweep", 1'b1, 1'b1);
    end
  endtask : sweep
  initial
  begin
    rst_seq(1'b1);
    c_lvl <= 6'h3f;
    n_lvl <= 6'h20;
    gate("serial soft", 1'b0, 1'b0);
    ss <= 1'b0;
    gate("serial boot", 1'b0, 1'b0);
    pg <= 1'b1;
    vid <= 1'b1;
    gate("serial normal", 1'b1, 1'b1);
    sweep();
    slow <= 1'b1;
    fixed <= 1'b1;
    gate("fixed", 1'b0, 1'b0);
    rst_seq(1'b0);
    gate("par soft", 1'b0, 1'b0);
    ss <= 1'b0;
    pg <= 1'b1;
    vid <= 1'b1;
    gate("par normal", 1'b1, 1'b0);
    pg <= 1'b0;
    gate("pg loss", 1'b0, 1'b0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire

// file: verilog/oodg_decode.sv
// ratio code to offset step decoder
`timescale 1ns/1ns
`default_nettype none
module oodg_decode
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // conversion result
  input wire logic load,
  input wire logic [oodg_pkg::ADC_W-1:0] ratio,
  // held offset code
  output logic [oodg_pkg::OFS_W-1:0] code_q
);
  logic [oodg_pkg::OFS_W-1:0] code_d;
  logic [oodg_pkg::OFS_W-1:0] band;

  always_comb
  begin
    // each 2/64 band from 3/64 up adds one 25 mV step
    band = 6'((ratio - oodg_pkg::RATIO_ZERO_LIM) >> 1) + 6'h01;
    code_d = code_q;
    if (load)
    begin
      if (ratio < oodg_pkg::RATIO_ZERO_LIM)
        code_d = oodg_pkg::OFS_ZERO;
      else if (ratio >= oodg_pkg::RATIO_FULL_LIM)
        code_d = oodg_pkg::OFS_MAX_CODE;
      else if (band > oodg_pkg::OFS_TOP_BAND)
        code_d = oodg_pkg::OFS_TOP_BAND;
      else
        code_d = band;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      code_q <= oodg_pkg::OFS_ZERO;
    else
      code_q <= code_d;
  end
endmodule : oodg_decode
`default_nettype wire

// file: verilog/oodg_pkg.sv
// constants and types for the output offset decode and gating block
package oodg_pkg;
  // converter code width (ratio in 1/64 steps of the supply)
  localparam int ADC_W = 6;
  // offset code: count of 25 mV steps, 0..32 (32 = 800 mV)
  localparam int OFS_W = 6;
  localparam logic [5:0] OFS_STEP_MV = 6'h19;
  localparam logic [5:0] OFS_MAX_CODE = 6'h20;
  localparam logic [5:0] OFS_TOP_BAND = 6'h1e;
  localparam logic [5:0] OFS_ZERO = 6'h00;
  // ratio thresholds in 1/64 units: 0.046875 = 3/64, 0.984375 = 63/64
  localparam logic [5:0] RATIO_ZERO_LIM = 6'h03;
  localparam logic [5:0] RATIO_FULL_LIM = 6'h3f;
  // reference width in mV units
  localparam int REF_W = 12;
  localparam logic [11:0] REF_RST = 12'h000;
  // operating states of the regulator
  typedef enum logic [2:0] {
    OODG_OFF = 3'b000,
    OODG_SOFT_START = 3'b001,
    OODG_BOOT = 3'b010,
    OODG_NORMAL = 3'b011,
    OODG_FIXED = 3'b100
  } oodg_state_t;
  // converter sequencer states
  typedef enum logic [1:0] {
    OODG_SEL_CORE = 2'b00,
    OODG_WAIT_CORE = 2'b01,
    OODG_SEL_NB = 2'b10,
    OODG_WAIT_NB = 2'b11
  } oodg_seq_t;
endpackage : oodg_pkg

// file: verilog/oodg_top.sv
// output offset decode and gating for core and northbridge rails
`timescale 1ns/1ns
`default_nettype none
module oodg_top
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // shared converter (pin select out, result in, done from pins domain)
  output logic adc_sel_nb_q,
  output logic adc_start_q,
  input wire logic adc_done,
  input wire logic [oodg_pkg::ADC_W-1:0] adc_ratio,
  // operating mode and sequence inputs
  input wire logic serial_vid_mode,
  input wire logic fixed_voltage_test_mode,
  input wire logic power_good_input,
  input wire logic soft_start_active,
  input wire logic vid_code_valid,
  // reference values before offset
  input wire logic [oodg_pkg::REF_W-1:0] reference_dac_value,
  input wire logic [oodg_pkg::REF_W-1:0] nb_reference_dac_value,
  // outputs
  output logic [oodg_pkg::REF_W-1:0] core_target_q,
  output logic [oodg_pkg::REF_W-1:0] nb_target_q,
  output logic [oodg_pkg::OFS_W-1:0] core_offset_q,
  output logic [oodg_pkg::OFS_W-1:0] northbridge_offset_pin_q,
  output logic core_offset_on_q,
  output logic northbridge_offset_pin_on_q,
  output logic normal_q
);
  // pin synchronisers (mode straps and converter handshake)
  logic [1:0] ser_s_q, fix_s_q, pg_s_q, ss_s_q, vid_s_q, done_s_q;
  logic done_prev_q;
  logic done_rise;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ser_s_q <= 2'b00;
      fix_s_q <= 2'b00;
      pg_s_q <= 2'b00;
      ss_s_q <= 2'b00;
      vid_s_q <= 2'b00;
      // reset high: a done left standing from before reset is no new edge
      done_s_q <= 2'b11;
      done_prev_q <= 1'b1;
    end
    else
    begin
      ser_s_q <= {ser_s_q[0], serial_vid_mode};
      fix_s_q <= {fix_s_q[0], fixed_voltage_test_mode};
      pg_s_q <= {pg_s_q[0], power_good_input};
      ss_s_q <= {ss_s_q[0], soft_start_active};
      vid_s_q <= {vid_s_q[0], vid_code_valid};
      done_s_q <= {done_s_q[0], adc_done};
      done_prev_q <= done_s_q[1];
    end
  end

  assign done_rise = done_s_q[1] & ~done_prev_q;

  // converter sequencer: alternate core and northbridge pins
  oodg_pkg::oodg_seq_t seq_q, seq_d;
  logic sel_nb_d, start_d;
  logic load_core, load_nb;

  always_comb
  begin
    seq_d = seq_q;
    sel_nb_d = adc_sel_nb_q;
    start_d = 1'b0;
    load_core = 1'b0;
    load_nb = 1'b0;
    case (seq_q)
      oodg_pkg::OODG_SEL_CORE:
      begin
        sel_nb_d = 1'b0;
        start_d = 1'b1;
        seq_d = oodg_pkg::OODG_WAIT_CORE;
      end
      oodg_pkg::OODG_WAIT_CORE:
        if (done_rise)
        begin
          load_core = 1'b1;
          seq_d = oodg_pkg::OODG_SEL_NB;
        end
      oodg_pkg::OODG_SEL_NB:
      begin
        sel_nb_d = 1'b1;
        start_d = 1'b1;
        seq_d = oodg_pkg::OODG_WAIT_NB;
      end
      oodg_pkg::OODG_WAIT_NB:
        if (done_rise)
        begin
          load_nb = 1'b1;
          seq_d = oodg_pkg::OODG_SEL_CORE;
        end
      default:
        seq_d = oodg_pkg::OODG_SEL_CORE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      seq_q <= oodg_pkg::OODG_SEL_CORE;
      adc_sel_nb_q <= 1'b0;
      adc_start_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      adc_sel_nb_q <= sel_nb_d;
      adc_start_q <= start_d;
    end
  end

  // one decoder per rail, shared converter result
  logic [oodg_pkg::OFS_W-1:0] core_code, nb_code;

  oodg_decode u_core_dec
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load_core),
    .ratio(adc_ratio),
    .code_q(core_code)
  );

  oodg_decode u_nb_dec
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load_nb),
    .ratio(adc_ratio),
    .code_q(nb_code)
  );

  // operating state
  oodg_pkg::oodg_state_t st_q, st_d;

  always_comb
  begin
    st_d = st_q;
    if (fix_s_q[1])
      st_d = oodg_pkg::OODG_FIXED;
    else
      case (st_q)
        oodg_pkg::OODG_OFF:
          if (ss_s_q[1])
            st_d = oodg_pkg::OODG_SOFT_START;
        oodg_pkg::OODG_SOFT_START:
          if (!ss_s_q[1])
            st_d = oodg_pkg::OODG_BOOT;
        oodg_pkg::OODG_BOOT:
          if (pg_s_q[1] && vid_s_q[1])
            st_d = oodg_pkg::OODG_NORMAL;
        oodg_pkg::OODG_NORMAL:
          if (!pg_s_q[1])
            st_d = oodg_pkg::OODG_BOOT;
        oodg_pkg::OODG_FIXED:
          st_d = oodg_pkg::OODG_OFF;
        default:
          st_d = oodg_pkg::OODG_OFF;
      endcase
    if (ss_s_q[1] && !fix_s_q[1])
      st_d = oodg_pkg::OODG_SOFT_START;
  end

  // mode gate and target sum
  logic core_on_d, nb_on_d, normal_d;
  logic [oodg_pkg::OFS_W-1:0] core_ofs_d, nb_ofs_d;
  logic [oodg_pkg::REF_W-1:0] core_tgt_d, nb_tgt_d;

  always_comb
  begin
    normal_d = (st_q == oodg_pkg::OODG_NORMAL);
    // soft-start, boot, fixed and off all withhold
    core_on_d = normal_d;
    nb_on_d = normal_d & ser_s_q[1];
    core_ofs_d = core_on_d ? core_code : oodg_pkg::OFS_ZERO;
    nb_ofs_d = nb_on_d ? nb_code : oodg_pkg::OFS_ZERO;
    // offset in mV added to the reference target
    core_tgt_d = reference_dac_value
      + 12'(core_ofs_d) * 12'(oodg_pkg::OFS_STEP_MV);
    nb_tgt_d = nb_reference_dac_value
      + 12'(nb_ofs_d) * 12'(oodg_pkg::OFS_STEP_MV);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= oodg_pkg::OODG_OFF;
      core_offset_on_q <= 1'b0;
      northbridge_offset_pin_on_q <= 1'b0;
      normal_q <= 1'b0;
      core_offset_q <= oodg_pkg::OFS_ZERO;
      northbridge_offset_pin_q <= oodg_pkg::OFS_ZERO;
      core_target_q <= oodg_pkg::REF_RST;
      nb_target_q <= oodg_pkg::REF_RST;
    end
    else
    begin
      st_q <= st_d;
      core_offset_on_q <= core_on_d;
      northbridge_offset_pin_on_q <= nb_on_d;
      normal_q <= normal_d;
      core_offset_q <= core_ofs_d;
      northbridge_offset_pin_q <= nb_ofs_d;
      core_target_q <= core_tgt_d;
      nb_target_q <= nb_tgt_d;
    end
  end
endmodule : oodg_top
`default_nettype wire
